// ---- verilog/timer_pkg.sv ----
// Notes on behaviour
// - square wave toggles on each A match
// - B match interrupt raised even unused
// - clock select 11 counts input A edges
// - first match A+2 edges, then A+1
// - input A needs two equal samples
// - edge-clear mode: A edge clears, else wraps
// - edge-clear mode counts immediately on entry
// - compare registers raise their match interrupt
// - capture A on B edge or reverse phase
// - capture B on A edge, then clear
// - output toggles on A match, on B match in edge-clear mode only, optionally on clear
// - A compare with B capture combination works
// - counter read leaves counting undisturbed
// - interval mode A match clears, interrupts, toggles
// - edge codes 00 fall, 01 rise, 11 both
// - mode 00 stops and initializes counter
package timer_pkg;
   // =====================================================
   // register byte offsets
   localparam logic [3:0] OFF_MODE = 4'h0;
   localparam logic [3:0] OFF_PRESCALE = 4'h4;
   localparam logic [3:0] OFF_CAPCMP = 4'h8;
   localparam logic [3:0] OFF_OUTCTRL = 4'hC;
   localparam logic [5:0] OFF_COUNT = 6'h10;
   localparam logic [5:0] OFF_REGA = 6'h14;
   localparam logic [5:0] OFF_REGB = 6'h18;
   // =====================================================
   // field positions
   localparam int MODE_LO_POS = 2;
   localparam int TOGCLR_POS = 1;
   localparam int CLKSEL_POS = 0;
   localparam int EDGEA_POS = 4;
   localparam int EDGEB_POS = 6;
   localparam int CAPA_POS = 0;
   localparam int REVPH_POS = 1;
   localparam int CAPB_POS = 2;
   localparam int OUTEN_POS = 0;
   // =====================================================
   // codes and reset values
   localparam logic [1:0] MODE_STOP = 2'h0;
   localparam logic [1:0] MODE_EDGECLR = 2'h2;
   localparam logic [1:0] MODE_INTERVAL = 2'h3;
   localparam logic [1:0] CLK_DIV1 = 2'h0;
   localparam logic [1:0] CLK_DIV4 = 2'h1;
   localparam logic [1:0] CLK_DIV256 = 2'h2;
   localparam logic [1:0] CLK_EDGE = 2'h3;
   localparam logic [1:0] EDGE_FALL = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_BOTH = 2'h3;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic [7:0] DIV_MAX = 8'hFF;
endpackage

// ---- verilog/timer_event_counter.sv ----
// Implementation choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
module timer_event_counter
   import timer_pkg::*;
(
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [5:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic extInputA,
   input wire logic extInputB,
   output logic toggleOutput,
   output logic matchIrqA,
   output logic matchIrqB
);
   // =====================================================
   // functions
   // valid edge test for a 2-bit selection code
   function automatic logic edgeHit(input logic [1:0] sel, input logic prev, input logic cur);
      logic rise;
      logic fall;
      rise = cur & ~prev;
      fall = prev & ~cur;
      unique case (sel)
         EDGE_FALL: edgeHit = fall;
         EDGE_RISE: edgeHit = rise;
         EDGE_BOTH: edgeHit = rise | fall;
         default: edgeHit = 1'b0; // prohibited code 10 detects nothing
      endcase
   endfunction

   // =====================================================
   // registers
   logic [7:0] timerModeCtrl_q;
   logic [7:0] prescalerCtrl_q;
   logic [7:0] capCmpCtrl_q;
   logic [7:0] outputCtrl_q;
   logic [15:0] countReg_q;
   logic [15:0] capCmpRegA_q;
   logic [15:0] capCmpRegB_q;
   logic [1:0] opMode;
   logic [1:0] clkSel;
   logic capAMode;
   logic capBMode;
   logic wbReq;
   logic wbWrite;

   assign opMode = timerModeCtrl_q[MODE_LO_POS +: 2];
   assign clkSel = prescalerCtrl_q[CLKSEL_POS +: 2];
   assign capAMode = capCmpCtrl_q[CAPA_POS];
   assign capBMode = capCmpCtrl_q[CAPB_POS];
   assign wbReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wbWrite = wbReq & wb_we_i & wb_sel_i[0];

   // =====================================================
   // input sampling and edge filter
   // a level counts only after two equal samples, so one-cycle glitches vanish
   logic [1:0] sampA_q;
   logic [1:0] sampB_q;
   logic fltA_q;
   logic fltB_q;
   logic edgeA;
   logic edgeB;
   logic revA;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         sampA_q <= 2'h0;
         sampB_q <= 2'h0;
         fltA_q <= 1'b0;
         fltB_q <= 1'b0;
      end else begin
         sampA_q <= {sampA_q[0], extInputA};
         sampB_q <= {sampB_q[0], extInputB};
         if (sampA_q[1] == sampA_q[0]) begin
            fltA_q <= sampA_q[0];
         end
         if (sampB_q[1] == sampB_q[0]) begin
            fltB_q <= sampB_q[0];
         end
      end
   end

   logic fltAPrev_q;
   logic fltBPrev_q;
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         fltAPrev_q <= 1'b0;
         fltBPrev_q <= 1'b0;
      end else begin
         fltAPrev_q <= fltA_q;
         fltBPrev_q <= fltB_q;
      end
   end

   always_comb begin
      edgeA = edgeHit(prescalerCtrl_q[EDGEA_POS +: 2], fltAPrev_q, fltA_q);
      edgeB = edgeHit(prescalerCtrl_q[EDGEB_POS +: 2], fltBPrev_q, fltB_q);
      // reverse phase of input A: the opposite transition of a single-edge select;
      // a both-edges select has no opposite phase, so it never fires
      revA = !prescalerCtrl_q[EDGEA_POS + 1] &&
         edgeHit({1'b0, ~prescalerCtrl_q[EDGEA_POS]}, fltAPrev_q, fltA_q);
   end

   // =====================================================
   // prescaler
   logic [7:0] div_q;
   logic tick;
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         div_q <= RST_BYTE;
      end else if (opMode == MODE_STOP) begin
         div_q <= RST_BYTE;
      end else begin
         div_q <= div_q + 8'h01;
      end
   end

   always_comb begin
      unique case (clkSel)
         CLK_DIV1: tick = opMode != MODE_STOP;
         CLK_DIV4: tick = (opMode != MODE_STOP) && (div_q[1:0] == 2'h3);
         CLK_DIV256: tick = (opMode != MODE_STOP) && (div_q == DIV_MAX);
         CLK_EDGE: tick = (opMode != MODE_STOP) && edgeA;
      endcase
   end

   // an edge-clocked count spends its first valid edge on starting, so the first
   // match needs one edge more than the later ones
   logic started_q;
   logic countTick;
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         started_q <= 1'b0;
      end else if (opMode == MODE_STOP) begin
         started_q <= 1'b0;
      end else if (tick) begin
         started_q <= 1'b1;
      end
   end
   assign countTick = tick && (started_q || clkSel != CLK_EDGE);

   // =====================================================
   // counter and events
   // match is checked on the held count, so an interval of M spans M + 1 ticks
   logic matchA;
   logic matchB;
   logic edgeClear;
   logic capAEvt;
   logic capBEvt;
   logic irqAEvt;
   logic irqBEvt;
   logic toggleEvt;

   always_comb begin
      matchA = countTick && !capAMode && (countReg_q == capCmpRegA_q);
      matchB = countTick && !capBMode && (countReg_q == capCmpRegB_q);
      edgeClear = (opMode == MODE_EDGECLR) && edgeA;
      capBEvt = edgeClear && capBMode;
      capAEvt = (opMode == MODE_EDGECLR) && capAMode &&
         (edgeB || (capCmpCtrl_q[REVPH_POS] && revA));
      irqAEvt = matchA || (capAEvt && edgeB);
      irqBEvt = matchB || capBEvt;
      // a B match moves the pin only in edge-clear mode; in interval mode it would
      // break the square wave
      toggleEvt = outputCtrl_q[OUTEN_POS] && (matchA || (matchB && opMode == MODE_EDGECLR) ||
         (edgeClear && timerModeCtrl_q[TOGCLR_POS]));
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         countReg_q <= RST_WORD;
      end else if (opMode == MODE_STOP) begin
         countReg_q <= RST_WORD;
      end else if (edgeClear) begin
         countReg_q <= RST_WORD;
      end else if (countTick) begin
         if (opMode == MODE_INTERVAL && matchA) begin
            countReg_q <= RST_WORD;
         end else begin
            countReg_q <= countReg_q + 16'h0001;
         end
      end
   end

   // interrupt pulses and output pin
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         matchIrqA <= 1'b0;
         matchIrqB <= 1'b0;
         toggleOutput <= 1'b0;
      end else begin
         matchIrqA <= irqAEvt && opMode != MODE_STOP;
         matchIrqB <= irqBEvt && opMode != MODE_STOP;
         if (!outputCtrl_q[OUTEN_POS]) begin
            toggleOutput <= 1'b0;
         end else if (toggleEvt) begin
            toggleOutput <= ~toggleOutput;
         end
      end
   end

   // =====================================================
   // control registers, software writes byte lane 0
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         timerModeCtrl_q <= RST_BYTE;
         prescalerCtrl_q <= RST_BYTE;
         capCmpCtrl_q <= RST_BYTE;
         outputCtrl_q <= RST_BYTE;
      end else if (wbWrite) begin
         if (wb_adr_i == {2'h0, OFF_MODE}) timerModeCtrl_q <= wb_dat_i[7:0];
         if (wb_adr_i == {2'h0, OFF_PRESCALE}) prescalerCtrl_q <= wb_dat_i[7:0];
         if (wb_adr_i == {2'h0, OFF_CAPCMP}) capCmpCtrl_q <= wb_dat_i[7:0];
         if (wb_adr_i == {2'h0, OFF_OUTCTRL}) outputCtrl_q <= wb_dat_i[7:0];
      end
   end

   // capture/compare registers; hardware capture wins over a software write
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         capCmpRegA_q <= RST_WORD;
         capCmpRegB_q <= RST_WORD;
      end else begin
         if (capAEvt) begin
            capCmpRegA_q <= countReg_q;
         end else if (wbWrite && wb_adr_i == OFF_REGA && wb_sel_i[1]) begin
            capCmpRegA_q <= wb_dat_i[15:0];
         end
         if (capBEvt) begin
            capCmpRegB_q <= countReg_q;
         end else if (wbWrite && wb_adr_i == OFF_REGB && wb_sel_i[1]) begin
            capCmpRegB_q <= wb_dat_i[15:0];
         end
      end
   end

   // =====================================================
   // wishbone answer: ack one cycle after request, unmapped reads zero
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= wbReq;
         if (wbReq && !wb_we_i) begin
            unique case (wb_adr_i)
               {2'h0, OFF_MODE}: wb_dat_o <= {24'h000000, timerModeCtrl_q};
               {2'h0, OFF_PRESCALE}: wb_dat_o <= {24'h000000, prescalerCtrl_q};
               {2'h0, OFF_CAPCMP}: wb_dat_o <= {24'h000000, capCmpCtrl_q};
               {2'h0, OFF_OUTCTRL}: wb_dat_o <= {24'h000000, outputCtrl_q};
               OFF_COUNT: wb_dat_o <= {16'h0000, countReg_q};
               OFF_REGA: wb_dat_o <= {16'h0000, capCmpRegA_q};
               OFF_REGB: wb_dat_o <= {16'h0000, capCmpRegB_q};
               default: wb_dat_o <= 32'h00000000;
            endcase
         end
      end
   end

   // =====================================================
   // checks
   stop_clears_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      opMode == MODE_STOP |=> countReg_q == RST_WORD)
      else $error("counter not cleared while stopped");
   interval_clear_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      (opMode == MODE_INTERVAL && matchA && !edgeClear) |=> countReg_q == RST_WORD && matchIrqA)
      else $error("interval match did not clear");
   edge_clear_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      edgeClear && opMode != MODE_STOP |=> countReg_q == RST_WORD)
      else $error("edge did not clear counter");
   capture_b_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      capBEvt |=> capCmpRegB_q == $past(countReg_q) && matchIrqB)
      else $error("capture into B wrong");
   toggle_out_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      toggleEvt |=> toggleOutput != $past(toggleOutput))
      else $error("output did not toggle");
   count_step_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      countTick && !edgeClear && !(opMode == MODE_INTERVAL && matchA) |=>
      countReg_q == $past(countReg_q) + 16'h0001)
      else $error("counter step wrong");
   event_start_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      tick && !started_q && clkSel == CLK_EDGE |=> countReg_q == RST_WORD)
      else $error("first event edge counted");
   irq_stop_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      opMode == MODE_STOP |=> !matchIrqA && !matchIrqB)
      else $error("interrupt while stopped");
   b_no_toggle_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      opMode == MODE_INTERVAL && outputCtrl_q[OUTEN_POS] && matchB && !matchA |=> $stable(toggleOutput))
      else $error("B match moved square wave");
   match_b_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      matchB |=> matchIrqB)
      else $error("B match not signalled");
   filter_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      $changed(fltA_q) |-> $past(sampA_q[1]) == $past(sampA_q[0]))
      else $error("filter took one sample");
   ack_once_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held two cycles");
endmodule // timer_event_counter

// ---- tb/pin_model.sv ----
`timescale 1ns/1ps
// =====================================================
// far-side pins: level pulses of a commanded width
module pin_model (
   input wire logic sys_clk,
   input wire logic reqA,
   input wire logic reqB,
   input wire logic [3:0] width,
   output logic pinA,
   output logic pinB
);
   logic [3:0] cntA;
   logic [3:0] cntB;
   // width 1 is a glitch the filter must drop; 2 and up pass it
   always @(posedge sys_clk) begin
      if (reqA) begin pinA <= 1'b1; cntA <= width; end
      else if (cntA > 4'h1) cntA <= cntA - 4'h1;
      else begin pinA <= 1'b0; cntA <= 4'h0; end
      if (reqB) begin pinB <= 1'b1; cntB <= width; end
      else if (cntB > 4'h1) cntB <= cntB - 4'h1;
      else begin pinB <= 1'b0; cntB <= 4'h0; end
   end
endmodule // pin_model

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
module tb_top
   import timer_pkg::*;
;
   logic sysClk = 1'b0, resetn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, reqA = 1'b0, reqB = 1'b0;
   logic [5:0] adr = 6'h00;
   logic [31:0] datW = 32'h0000_0000, rdat, datO, lfsrQ = 32'hEE576B50;
   logic [3:0] width = 4'h3;
   logic ack, pinA, pinB, togOut, irqA, irqB, tog0;
   logic [15:0] m, c1, c2;
   int n_fail = 0, samples_checked = 0, cycles = 0, t0, nIrqA = 0, n0;
   always #2.5 sysClk = ~sysClk;
   timer_event_counter i_timer_event_counter (.sys_clk(sysClk), .resetn(resetn), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(datW), .wb_dat_o(datO),
      .wb_ack_o(ack), .extInputA(pinA), .extInputB(pinB), .toggleOutput(togOut), .matchIrqA(irqA),
      .matchIrqB(irqB));
   pin_model i_pin_model (.sys_clk(sysClk), .reqA(reqA), .reqB(reqB), .width(width), .pinA(pinA),
      .pinB(pinB));
   // =====================================================
   // helpers
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input bit ok, input string msg);
      samples_checked++;
      if (!ok) begin n_fail++; $display("wrong value at %0t: %s", $time, msg); end
   endtask
   // classic cycle: hold until ack sampled high, then one idle cycle
   task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d);
      @(posedge sysClk);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; datW <= d;
      do @(posedge sysClk); while (ack !== 1'b1);
      rdat = datO;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
      @(posedge sysClk);
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] d); xfer(1'b1, a, d); endtask
   task automatic pulse(input bit onB, input logic [3:0] w);
      @(posedge sysClk);
      if (onB) reqB <= 1'b1; else reqA <= 1'b1;
      width <= w;
      @(posedge sysClk);
      reqA <= 1'b0; reqB <= 1'b0;
      repeat (int'(w) + 8) @(posedge sysClk);
   endtask
   // bounded wait for a one-cycle interrupt pulse
   task automatic waitIrq(input bit onB);
      int k;
      for (k = 0; k < 2000 && (onB ? irqB : irqA) !== 1'b1; k++) @(posedge sysClk);
      chk(k < 2000, "interrupt pulse missing");
   endtask
   // A interrupt pulses seen, so event-count scenarios can count them
   always @(posedge sysClk) begin
      if (irqA === 1'b1) nIrqA <= nIrqA + 1;
   end
   always @(posedge sysClk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin n_fail++; print_verdict(); end
   end
   // =====================================================
   // main sequence
   initial begin
      repeat (6) @(posedge sysClk);
      resetn <= 1'b1;
      xfer(1'b0, OFF_COUNT, 0); chk(rdat === 32'h0 && irqA === 1'b0 && irqB === 1'b0, "reset state");
      xfer(1'b0, 6'h3C, 0); chk(rdat === 32'h0, "unmapped read");
      // interval mode, random period, output enabled
      lfsrQ = lfsr(lfsrQ);
      m = 16'h2 + 16'(lfsrQ[2:0]);
      wr(OFF_REGA, 32'(m)); wr(OFF_REGB, 32'h1); wr({2'h0, OFF_OUTCTRL}, 32'h1); wr({2'h0, OFF_PRESCALE}, 32'h0);
      wr({2'h0, OFF_MODE}, 32'(MODE_INTERVAL) << MODE_LO_POS);
      waitIrq(1'b1);
      waitIrq(1'b0); t0 = cycles; tog0 = togOut; @(posedge sysClk);
      waitIrq(1'b0);
      chk(cycles - t0 == int'(m) + 1, "interval period");
      chk(togOut !== tog0, "square wave toggle");
      wr({2'h0, OFF_MODE}, 32'(MODE_STOP));
      xfer(1'b0, OFF_COUNT, 0); c1 = rdat[15:0]; xfer(1'b0, OFF_COUNT, 0);
      chk(c1 === RST_WORD && rdat[15:0] === RST_WORD, "stopped counter");
      // edge-clear mode, both registers capture, toggle on clear
      wr({2'h0, OFF_PRESCALE}, 32'(EDGE_RISE) << EDGEA_POS | 32'(EDGE_RISE) << EDGEB_POS);
      wr({2'h0, OFF_CAPCMP}, 32'h5);
      wr({2'h0, OFF_MODE}, 32'(MODE_EDGECLR) << MODE_LO_POS | 32'h1 << TOGCLR_POS);
      xfer(1'b0, OFF_COUNT, 0); c1 = rdat[15:0]; xfer(1'b0, OFF_COUNT, 0);
      chk(rdat[15:0] > c1 && c1 > 16'h0, "counting on entry");
      c1 = rdat[15:0];
      pulse(1'b0, 4'h1);
      xfer(1'b0, OFF_COUNT, 0); c2 = rdat[15:0];
      // about fifteen cycles pass between the reads; a false clear would leave far less
      chk(c2 > c1 + 16'hB, "glitch ignored");
      tog0 = togOut;
      pulse(1'b0, 4'h4);
      xfer(1'b0, OFF_REGB, 0); chk(rdat[15:0] > c2, "capture into B");
      xfer(1'b0, OFF_COUNT, 0); chk(rdat[15:0] < 16'h20, "cleared by edge");
      chk(togOut !== tog0, "toggle on clear");
      fork pulse(1'b1, 4'h4); waitIrq(1'b0); join
      xfer(1'b0, OFF_REGA, 0); chk(rdat[15:0] !== 16'(m) && rdat[15:0] !== 16'h0, "capture into A");
      // A compares while B captures: the A edge clears, the A match comes M + 1 ticks later
      wr({2'h0, OFF_CAPCMP}, 32'h4); wr(OFF_REGA, 32'(m));
      fork
         pulse(1'b0, 4'h4);
         begin
            waitIrq(1'b1);
            t0 = cycles;
            waitIrq(1'b0);
            chk(cycles - t0 == int'(m) + 1, "compare after capture");
         end
      join
      // event counting for each edge code; the first edge only starts the count
      for (int e = 0; e < 3; e++) begin
         wr({2'h0, OFF_MODE}, 32'(MODE_STOP));
         wr({2'h0, OFF_CAPCMP}, 32'h0); wr(OFF_REGA, 32'h100);
         wr({2'h0, OFF_PRESCALE}, (e == 2 ? 32'h3 : 32'(e)) << EDGEA_POS | 32'(CLK_EDGE));
         wr({2'h0, OFF_MODE}, 32'(MODE_INTERVAL) << MODE_LO_POS);
         repeat (2) pulse(1'b0, 4'h3);
         xfer(1'b0, OFF_COUNT, 0);
         chk(rdat[15:0] === (e == 2 ? 16'h3 : 16'h1), "event count per edge code");
      end
      // first match after A + 2 edges, later ones after A + 1
      wr({2'h0, OFF_MODE}, 32'(MODE_STOP)); wr(OFF_REGA, 32'h3);
      wr({2'h0, OFF_PRESCALE}, 32'(EDGE_RISE) << EDGEA_POS | 32'(CLK_EDGE));
      wr({2'h0, OFF_MODE}, 32'(MODE_INTERVAL) << MODE_LO_POS);
      n0 = nIrqA;
      repeat (4) pulse(1'b0, 4'h3);
      chk(nIrqA == n0, "match before A + 2 edges");
      pulse(1'b0, 4'h3);
      chk(nIrqA == n0 + 1, "first event match");
      repeat (3) pulse(1'b0, 4'h3);
      xfer(1'b0, OFF_COUNT, 0); chk(rdat[15:0] === 16'h3 && nIrqA == n0 + 1, "event counter value");
      pulse(1'b0, 4'h3);
      chk(nIrqA == n0 + 2, "later event match");
      print_verdict();
   end
endmodule // tb_top
